// *** design/imu_pkg.sv ***
// integer multiply unit: shared constants, register map, field layout and types
// assumes a single 50 MHz core clock and a synchronous active-high reset
package imu_pkg;

  // data widths
  localparam int unsigned IMU_DW       = 32;             // word width
  localparam int unsigned IMU_AW       = 8;              // byte address width seen by the slave
  localparam int unsigned IMU_RIDX_W   = 4;              // register index width (r0..r15)

  // register byte offsets
  localparam logic [7:0] IMU_OFF_CTRL   = 8'h00;         // operation, options, indices, start
  localparam logic [7:0] IMU_OFF_OPA    = 8'h04;         // first operand value
  localparam logic [7:0] IMU_OFF_OPB    = 8'h08;         // second operand value
  localparam logic [7:0] IMU_OFF_ADDEND = 8'h0C;         // addend value
  localparam logic [7:0] IMU_OFF_ACCHI  = 8'h10;         // prior high destination value
  localparam logic [7:0] IMU_OFF_ACCLO  = 8'h14;         // prior low destination value
  localparam logic [7:0] IMU_OFF_RESLO  = 8'h18;         // last low result (read only)
  localparam logic [7:0] IMU_OFF_RESHI  = 8'h1C;         // last high result (read only)
  localparam logic [7:0] IMU_OFF_FLAGS  = 8'h20;         // n z c v flags
  localparam logic [7:0] IMU_OFF_STATUS = 8'h24;         // busy, done, bad op

  // control field positions
  localparam int unsigned IMU_CTRL_OP_LSB    = 0;        // op code [2:0]
  localparam int unsigned IMU_CTRL_SETF_BIT  = 3;        // flag-setting form
  localparam int unsigned IMU_CTRL_COND_BIT  = 4;        // condition passed
  localparam int unsigned IMU_CTRL_DGIV_BIT  = 5;        // destination index given
  localparam int unsigned IMU_CTRL_DIDX_LSB  = 8;        // destination / low destination index
  localparam int unsigned IMU_CTRL_NIDX_LSB  = 12;       // first operand register index
  localparam int unsigned IMU_CTRL_HIDX_LSB  = 16;       // high destination index
  localparam int unsigned IMU_CTRL_START_BIT = 31;       // start strobe, reads zero

  // flag and status bit positions
  localparam int unsigned IMU_FLAG_V = 0;
  localparam int unsigned IMU_FLAG_C = 1;
  localparam int unsigned IMU_FLAG_Z = 2;
  localparam int unsigned IMU_FLAG_N = 3;
  localparam int unsigned IMU_ST_BUSY = 0;
  localparam int unsigned IMU_ST_DONE = 1;
  localparam int unsigned IMU_ST_BAD  = 2;

  // reset values
  localparam logic [31:0] IMU_RST_WORD  = 32'h0000_0000;
  localparam logic [3:0]  IMU_RST_FLAGS = 4'h0;

  // operation codes held in the control register
  typedef enum logic [2:0] {
    IMU_OP_LOW_WORD   = 3'h0,   // product_low_word
    IMU_OP_ACCUMULATE = 3'h1,   // product_accumulate
    IMU_OP_SUBTRACT   = 3'h2,   // product_subtract
    IMU_OP_WIDE_PROD  = 3'h3,   // unsigned_wide_product
    IMU_OP_WIDE_DADD  = 3'h4,   // unsigned_wide_double_add
    IMU_OP_WIDE_ACC   = 3'h5    // unsigned_wide_accumulate
  } imu_op_t;

  // sequencer states
  typedef enum logic [1:0] {
    IMU_S_IDLE,
    IMU_S_CALC,
    IMU_S_WRITE
  } imu_state_t;

endpackage

// *** design/imu_calc_if.sv ***
// integer multiply unit: carrier between the sequencer and the arithmetic core
// assumes both ends sit on the same clock; the core is purely combinational
`timescale 1ns/1ps
`default_nettype none
interface imu_calc_if;
  import imu_pkg::*;
  logic [2:0]  op;        // operation code
  logic [31:0] opa;       // first operand
  logic [31:0] opb;       // second operand
  logic [31:0] addend;    // addend for accumulate / subtract
  logic [31:0] acc_hi;    // prior high destination value
  logic [31:0] acc_lo;    // prior low destination value
  logic [31:0] res_lo;    // low result word
  logic [31:0] res_hi;    // high result word
  logic        valid_op;  // op code is one of the six

  modport seq  (output op, opa, opb, addend, acc_hi, acc_lo, input res_lo, res_hi, valid_op);
  modport core (input op, opa, opb, addend, acc_hi, acc_lo, output res_lo, res_hi, valid_op);
endinterface
`default_nettype wire

// *** design/imu_calc.sv ***
// integer multiply unit: arithmetic core for all six operations
// assumes operands are stable while the sequencer samples the result
`timescale 1ns/1ps
`default_nettype none
module imu_calc
  import imu_pkg::*;
(
  // carrier to the sequencer
  imu_calc_if.core calc
);

  logic [63:0] prod;   // full unsigned product
  logic [63:0] sum;    // selected 64-bit result

  // one shared 32x32 product; signedness does not matter for the low word
  always_comb
  begin
    prod           = 64'(calc.opa) * 64'(calc.opb);
    calc.valid_op  = 1'b1;
    case (calc.op)
      IMU_OP_LOW_WORD:   sum = {32'h0000_0000, prod[31:0]};
      IMU_OP_ACCUMULATE: sum = {32'h0000_0000, prod[31:0] + calc.addend};
      IMU_OP_SUBTRACT:   sum = {32'h0000_0000, calc.addend - prod[31:0]};
      IMU_OP_WIDE_PROD:  sum = prod;
      // both prior words zero-extended, then split hi/lo
      IMU_OP_WIDE_DADD:  sum = prod + {32'h0000_0000, calc.acc_hi}
                               + {32'h0000_0000, calc.acc_lo};
      IMU_OP_WIDE_ACC:   sum = prod + {calc.acc_hi, calc.acc_lo};
      default:
      begin
        sum           = 64'h0000_0000_0000_0000;
        calc.valid_op = 1'b0;
      end
    endcase
    calc.res_lo = sum[31:0];
    calc.res_hi = sum[63:32];
  end

endmodule
`default_nettype wire

// *** design/imu_top.sv ***
// integer multiply unit: wishbone register block, sequencer and write-back port
// assumes a classic wishbone master and a register file that takes the write-back pulses
//
// How it works
// - low word of product to destination
// - product plus addend, low word kept
// - addend minus product, low word kept
// - same result for signed or unsigned operands
// - missing destination means first operand register
// - flag form of the low word operation updates n and z only
// - wide family treats operands as unsigned
// - wide product splits into high, low pair
// - double add adds both prior words
// - double add sum split into high, low
// - wide accumulate adds pair to product
// - wide family leaves all flags unchanged
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module imu_top
  import imu_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // low destination write-back
  output logic             rf_lo_we_o,
  output logic      [3:0]  rf_lo_idx_o,
  output logic      [31:0] rf_lo_data_o,
  // high destination write-back
  output logic             rf_hi_we_o,
  output logic      [3:0]  rf_hi_idx_o,
  output logic      [31:0] rf_hi_data_o,
  // condition flags and completion
  output logic      [3:0]  flags_o,
  output logic             done_o
);

  // byte-lane merge, used by the control, operand, addend and prior destination registers
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  // true for the three 64-bit result operations
  function automatic logic is_wide(input logic [2:0] op);
    return (op == IMU_OP_WIDE_PROD) || (op == IMU_OP_WIDE_DADD) || (op == IMU_OP_WIDE_ACC);
  endfunction

  // ---------------- bus slave state ----------------
  logic        ack_q,  ack_d;       // ack, one cycle per request
  logic [31:0] rdat_q, rdat_d;      // read data register
  logic        wr_go;               // write commits at the acked edge
  logic        start_req;           // start bit written this edge

  // ---------------- software-visible registers ----------------
  logic [31:0] ctrl_q,   ctrl_d;    // control word, start bit never stored
  logic [31:0] opa_q,    opa_d;     // first operand
  logic [31:0] opb_q,    opb_d;     // second operand
  logic [31:0] add_q,    add_d;     // addend
  logic [31:0] acchi_q,  acchi_d;   // prior high destination
  logic [31:0] acclo_q,  acclo_d;   // prior low destination
  logic [31:0] reslo_q,  reslo_d;   // last low result
  logic [31:0] reshi_q,  reshi_d;   // last high result
  logic [3:0]  flags_q,  flags_d;   // n z c v
  logic        sdone_q,  sdone_d;   // sticky done
  logic        sbad_q,   sbad_d;    // sticky bad op code

  // ---------------- sequencer and write-back ----------------
  imu_state_t  state_q,  state_d;   // sequencer state
  logic        lowe_q,   lowe_d;    // low write strobe
  logic        hiwe_q,   hiwe_d;    // high write strobe
  logic [3:0]  loidx_q,  loidx_d;   // low destination index
  logic [3:0]  hiidx_q,  hiidx_d;   // high destination index
  logic        done_q,   done_d;    // completion pulse

  // decoded control fields
  logic [2:0]  c_op;
  logic        c_setf, c_cond, c_dgiv;
  logic [3:0]  c_didx, c_nidx, c_hidx;

  assign c_op   = ctrl_q[IMU_CTRL_OP_LSB +: 3];
  assign c_setf = ctrl_q[IMU_CTRL_SETF_BIT];
  assign c_cond = ctrl_q[IMU_CTRL_COND_BIT];
  assign c_dgiv = ctrl_q[IMU_CTRL_DGIV_BIT];
  assign c_didx = ctrl_q[IMU_CTRL_DIDX_LSB +: 4];
  assign c_nidx = ctrl_q[IMU_CTRL_NIDX_LSB +: 4];
  assign c_hidx = ctrl_q[IMU_CTRL_HIDX_LSB +: 4];

  // arithmetic core on the carrier
  imu_calc_if calc_bus ();
  assign calc_bus.op     = c_op;
  assign calc_bus.opa    = opa_q;
  assign calc_bus.opb    = opb_q;
  assign calc_bus.addend = add_q;
  assign calc_bus.acc_hi = acchi_q;
  assign calc_bus.acc_lo = acclo_q;

  imu_calc u_calc (
    .calc (calc_bus.core)
  );

  // bus handshake: ack rises one edge after the request, read data loaded with it;
  // the write itself lands on the next edge, where the master sees ack high
  always_comb
  begin
    ack_d  = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d = rdat_q;
    if (ack_d && !wb_we_i)
    begin
      case (wb_adr_i)
        IMU_OFF_CTRL:   rdat_d = ctrl_q;
        IMU_OFF_OPA:    rdat_d = opa_q;
        IMU_OFF_OPB:    rdat_d = opb_q;
        IMU_OFF_ADDEND: rdat_d = add_q;
        IMU_OFF_ACCHI:  rdat_d = acchi_q;
        IMU_OFF_ACCLO:  rdat_d = acclo_q;
        IMU_OFF_RESLO:  rdat_d = reslo_q;
        IMU_OFF_RESHI:  rdat_d = reshi_q;
        IMU_OFF_FLAGS:  rdat_d = {28'h000_0000, flags_q};
        IMU_OFF_STATUS: rdat_d = {29'h0000_0000, sbad_q, sdone_q, state_q != IMU_S_IDLE};
        default:        rdat_d = IMU_RST_WORD;   // unmapped reads as zero, still acked
      endcase
    end
  end

  // bus registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q  <= 1'b0;
      rdat_q <= IMU_RST_WORD;
    end
    else
    begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wr_go     = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  // start only counts while idle; a start during a run is dropped
  assign start_req = wr_go && (wb_adr_i == IMU_OFF_CTRL) && wb_sel_i[3]
                     && wb_dat_i[IMU_CTRL_START_BIT] && (state_q == IMU_S_IDLE);

  // register file next values; hardware results are taken after bus writes so they win
  always_comb
  begin
    ctrl_d  = ctrl_q;
    opa_d   = opa_q;
    opb_d   = opb_q;
    add_d   = add_q;
    acchi_d = acchi_q;
    acclo_d = acclo_q;
    reslo_d = reslo_q;
    reshi_d = reshi_q;
    flags_d = flags_q;
    sdone_d = sdone_q;
    sbad_d  = sbad_q;
    if (wr_go)
    begin
      case (wb_adr_i)
        // operands are held steady while a run is in flight
        IMU_OFF_CTRL:
        begin
          if (state_q == IMU_S_IDLE)
          begin
            ctrl_d = lane_merge(ctrl_q, wb_dat_i, wb_sel_i);
            ctrl_d[IMU_CTRL_START_BIT] = 1'b0;
          end
        end
        IMU_OFF_OPA:    if (state_q == IMU_S_IDLE) opa_d   = lane_merge(opa_q, wb_dat_i, wb_sel_i);
        IMU_OFF_OPB:    if (state_q == IMU_S_IDLE) opb_d   = lane_merge(opb_q, wb_dat_i, wb_sel_i);
        IMU_OFF_ADDEND: if (state_q == IMU_S_IDLE) add_d   = lane_merge(add_q, wb_dat_i, wb_sel_i);
        IMU_OFF_ACCHI:  if (state_q == IMU_S_IDLE) acchi_d = lane_merge(acchi_q, wb_dat_i, wb_sel_i);
        IMU_OFF_ACCLO:  if (state_q == IMU_S_IDLE) acclo_d = lane_merge(acclo_q, wb_dat_i, wb_sel_i);
        IMU_OFF_FLAGS:
        begin
          if (wb_sel_i[0] && state_q == IMU_S_IDLE)
            flags_d = wb_dat_i[3:0];
        end
        // write one to clear the sticky bits
        IMU_OFF_STATUS:
        begin
          if (wb_sel_i[0] && wb_dat_i[IMU_ST_DONE])
            sdone_d = 1'b0;
          if (wb_sel_i[0] && wb_dat_i[IMU_ST_BAD])
            sbad_d = 1'b0;
        end
        default:
        begin
          // unmapped and read-only offsets ignore writes
        end
      endcase
    end
    // the calc cycle captures results; set beats a clear in the same edge
    if (state_q == IMU_S_CALC)
    begin
      sdone_d = 1'b1;
      if (!calc_bus.valid_op)
        sbad_d = 1'b1;
      else if (c_cond)
      begin
        reslo_d = calc_bus.res_lo;
        reshi_d = is_wide(c_op) ? calc_bus.res_hi : IMU_RST_WORD;
        // only the flag-setting low word form touches n and z; c and v are kept
        if ((c_op == IMU_OP_LOW_WORD) && c_setf)
        begin
          flags_d[IMU_FLAG_N] = calc_bus.res_lo[31];
          flags_d[IMU_FLAG_Z] = (calc_bus.res_lo == IMU_RST_WORD);
        end
        // every other form, wide or plain narrow, leaves all four flags as they were
      end
    end
  end

  // register file flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q  <= IMU_RST_WORD;
      opa_q   <= IMU_RST_WORD;
      opb_q   <= IMU_RST_WORD;
      add_q   <= IMU_RST_WORD;
      acchi_q <= IMU_RST_WORD;
      acclo_q <= IMU_RST_WORD;
      reslo_q <= IMU_RST_WORD;
      reshi_q <= IMU_RST_WORD;
      flags_q <= IMU_RST_FLAGS;
      sdone_q <= 1'b0;
      sbad_q  <= 1'b0;
    end
    else
    begin
      ctrl_q  <= ctrl_d;
      opa_q   <= opa_d;
      opb_q   <= opb_d;
      add_q   <= add_d;
      acchi_q <= acchi_d;
      acclo_q <= acclo_d;
      reslo_q <= reslo_d;
      reshi_q <= reshi_d;
      flags_q <= flags_d;
      sdone_q <= sdone_d;
      sbad_q  <= sbad_d;
    end
  end

  // sequencer: idle -> calc (results captured) -> write (strobes out for one cycle)
  always_comb
  begin
    state_d = state_q;
    lowe_d  = 1'b0;
    hiwe_d  = 1'b0;
    loidx_d = loidx_q;
    hiidx_d = hiidx_q;
    done_d  = 1'b0;
    case (state_q)
      IMU_S_IDLE:
      begin
        if (start_req)
          state_d = IMU_S_CALC;
      end
      IMU_S_CALC:
      begin
        state_d = IMU_S_WRITE;
        done_d  = 1'b1;
        if (calc_bus.valid_op && c_cond)
        begin
          if (is_wide(c_op))
          begin
            // the source keeps the two indices distinct, so both strobes may fire together
            lowe_d  = 1'b1;
            hiwe_d  = 1'b1;
            loidx_d = c_didx;
            hiidx_d = c_hidx;
          end
          else
          begin
            // stack pointer and program counter never reach here as indices
            lowe_d  = 1'b1;
            loidx_d = c_dgiv ? c_didx : c_nidx;
          end
        end
      end
      IMU_S_WRITE:
      begin
        state_d = IMU_S_IDLE;
      end
      default:
      begin
        state_d = IMU_S_IDLE;
      end
    endcase
  end

  // sequencer flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= IMU_S_IDLE;
      lowe_q  <= 1'b0;
      hiwe_q  <= 1'b0;
      loidx_q <= 4'h0;
      hiidx_q <= 4'h0;
      done_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      lowe_q  <= lowe_d;
      hiwe_q  <= hiwe_d;
      loidx_q <= loidx_d;
      hiidx_q <= hiidx_d;
      done_q  <= done_d;
    end
  end

  // every output comes straight from a flop
  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = rdat_q;
  assign rf_lo_we_o   = lowe_q;
  assign rf_lo_idx_o  = loidx_q;
  assign rf_lo_data_o = reslo_q;
  assign rf_hi_we_o   = hiwe_q;
  assign rf_hi_idx_o  = hiidx_q;
  assign rf_hi_data_o = reshi_q;
  assign flags_o      = flags_q;
  assign done_o       = done_q;

endmodule
`default_nettype wire

// *** bench/imu_checker.sv ***
// integer multiply unit: port-level checker for bus answers and write-back timing
// assumes a master that never starts an operation while the unit is busy
`timescale 1ns/1ps
`default_nettype none
module imu_checker
  import imu_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone slave
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // write-back and flags
  input wire logic        rf_lo_we_o,
  input wire logic [3:0]  rf_lo_idx_o,
  input wire logic [31:0] rf_lo_data_o,
  input wire logic        rf_hi_we_o,
  input wire logic [3:0]  rf_hi_idx_o,
  input wire logic [31:0] rf_hi_data_o,
  input wire logic [3:0]  flags_o,
  input wire logic        done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // control write with start, committed at the edge that sees ack
  sequence s_start;
    wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == IMU_OFF_CTRL && wb_sel_i[3] && wb_dat_i[31];
  endsequence
  // start of a narrow operation whose condition passed
  sequence s_narrow;
    s_start ##0 (wb_dat_i[2:0] < 3'h3 && wb_dat_i[4]);
  endsequence
  // start of a wide operation whose condition passed
  sequence s_wide;
    s_start ##0 (wb_dat_i[2:0] inside {3'h3, 3'h4, 3'h5} && wb_dat_i[4]);
  endsequence

  property p_ack_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  property p_ack_single;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_start_done;
    s_start |-> ##2 done_o;
  endproperty
  property p_narrow_write;
    s_narrow ##0 wb_dat_i[5] |-> ##2 rf_lo_we_o && !rf_hi_we_o && rf_lo_idx_o == $past(wb_dat_i[11:8], 2);
  endproperty
  property p_dest_default;
    s_narrow ##0 !wb_dat_i[5] |-> ##2 rf_lo_we_o && rf_lo_idx_o == $past(wb_dat_i[15:12], 2);
  endproperty
  property p_wide_write;
    s_wide |-> ##2 rf_lo_we_o && rf_hi_we_o && rf_hi_idx_o == $past(wb_dat_i[19:16], 2);
  endproperty
  property p_wide_flags;
    s_wide |-> ##2 $stable(flags_o);
  endproperty
  property p_cond_false;
    s_start ##0 !wb_dat_i[4] |-> ##2 done_o && !rf_lo_we_o && !rf_hi_we_o && $stable(flags_o);
  endproperty
  property p_flag_update;
    s_narrow ##0 (wb_dat_i[2:0] == 3'h0 && wb_dat_i[3]) |-> ##2
      flags_o[3] == rf_lo_data_o[31] && flags_o[2] == (rf_lo_data_o == 32'h0000_0000) && flags_o[1:0] == $past(flags_o[1:0]);
  endproperty
  // flags move only with an operation or a committed software write
  property p_flags_cause;
    !$stable(flags_o) |-> done_o || $past(wb_ack_o && wb_we_i && wb_adr_i == IMU_OFF_FLAGS);
  endproperty

  a_ack_answer:   assert property (p_ack_answer)   else $error("bus request not answered next cycle");
  a_ack_single:   assert property (p_ack_single)   else $error("ack longer than one cycle");
  a_start_done:   assert property (p_start_done)   else $error("done missing two cycles after start");
  a_narrow_write: assert property (p_narrow_write) else $error("narrow write-back wrong");
  a_dest_default: assert property (p_dest_default) else $error("default destination wrong");
  a_wide_write:   assert property (p_wide_write)   else $error("wide write-back pair wrong");
  a_wide_flags:   assert property (p_wide_flags)   else $error("wide operation changed flags");
  a_cond_false:   assert property (p_cond_false)   else $error("failed condition still wrote");
  a_flag_update:  assert property (p_flag_update)  else $error("n z c v update wrong");
  a_flags_cause:  assert property (p_flags_cause)  else $error("flags changed without cause");
endmodule

bind imu_top imu_checker chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .rf_lo_we_o, .rf_lo_idx_o, .rf_lo_data_o, .rf_hi_we_o, .rf_hi_idx_o, .rf_hi_data_o,
  .flags_o, .done_o);
`default_nettype wire

// *** bench/imu_rf_model.sv ***
// integer multiply unit: register file model on the write-back side
// assumes one-cycle write pulses; no read path, the bench looks into regs_q
`timescale 1ns/1ps
`default_nettype none
module imu_rf_model (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // low and high write-back
  input wire logic        lo_we_i,
  input wire logic [3:0]  lo_idx_i,
  input wire logic [31:0] lo_data_i,
  input wire logic        hi_we_i,
  input wire logic [3:0]  hi_idx_i,
  input wire logic [31:0] hi_data_i
);
  logic [31:0] regs_q [16]; // sixteen general registers
  int          n_wr;        // strobes taken so far
  // high written last: a shared index would hide the low word, so sources keep them distinct
  always @(posedge clk_i)
  begin
    if (rst_i)
      n_wr <= 0;
    else
      n_wr <= n_wr + int'(lo_we_i) + int'(hi_we_i);
    if (lo_we_i)
      regs_q[lo_idx_i] <= lo_data_i;
    if (hi_we_i)
      regs_q[hi_idx_i] <= hi_data_i;
  end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// integer multiply unit: self-checking bench, the bench plays the decoder
// assumes imu_top answers each bus request one cycle after it is seen
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import imu_pkg::*;
;
  logic        clk_i = 1'b0;   // 50 MHz core clock
  logic        rst_i = 1'b1;   // held for 20 cycles
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, rf_lo_data_o, rf_hi_data_o, rd_q, g_lo, g_hi;
  logic [3:0]  rf_lo_idx_o, rf_hi_idx_o, flags_o, g_lo_idx, g_hi_idx, g_flags;
  logic        wb_ack_o, rf_lo_we_o, rf_hi_we_o, done_o, g_lo_we, g_hi_we, g_done;
  int          n_errors = 0;
  int          n_checks = 0;
  int          n_cyc = 0;

  always #10 clk_i = ~clk_i;

  imu_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .rf_lo_we_o, .rf_lo_idx_o, .rf_lo_data_o, .rf_hi_we_o, .rf_hi_idx_o, .rf_hi_data_o, .flags_o, .done_o);
  imu_rf_model rf_u (.clk_i, .rst_i, .lo_we_i(rf_lo_we_o), .lo_idx_i(rf_lo_idx_o), .lo_data_i(rf_lo_data_o),
    .hi_we_i(rf_hi_we_o), .hi_idx_i(rf_hi_idx_o), .hi_data_i(rf_hi_data_o));

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge clk_i)
  begin
    n_cyc++;
    if (n_cyc == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  // one classic cycle; request held up to the edge that samples ack high, read data taken at that edge;
  // no local limit, a lost ack is caught by the cycle ceiling
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack_o !== 1'b1);
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  function automatic logic [31:0] ctl(input logic [2:0] op, input logic sf, input logic cp, input logic dg,
                                      input logic [3:0] di, input logic [3:0] ni, input logic [3:0] hi);
    return {12'h000, hi, ni, di, 2'b00, dg, cp, sf, op};
  endfunction

  // load operands, start, and capture the write-back cycle
  task automatic run(input logic [31:0] c, input logic [31:0] a, b, ad, hi, lo);
    int n;
    wb(1'b1, IMU_OFF_OPA, a, 4'hF);
    wb(1'b1, IMU_OFF_OPB, b, 4'hF);
    wb(1'b1, IMU_OFF_ADDEND, ad, 4'hF);
    wb(1'b1, IMU_OFF_ACCHI, hi, 4'hF);
    wb(1'b1, IMU_OFF_ACCLO, lo, 4'hF);
    wb(1'b1, IMU_OFF_CTRL, c | 32'h8000_0000, 4'hF);
    n = 0;
    g_done = 1'b0;
    while (n < 10 && !g_done)
    begin
      @(negedge clk_i);
      n++;
      g_done = (done_o === 1'b1);
    end
    {g_lo_we, g_hi_we, g_lo_idx, g_hi_idx, g_lo, g_hi, g_flags} =
      {rf_lo_we_o, rf_hi_we_o, rf_lo_idx_o, rf_hi_idx_o, rf_lo_data_o, rf_hi_data_o, flags_o};
    chk("done", 1'b1, g_done);
    @(negedge clk_i);
  endtask

  // narrow family with a negative operand; flags preset to all ones must survive
  task automatic t_narrow;
    logic [31:0] a, b, c, e;
    a = 32'hFFFF_FFFE;
    b = 32'h0000_0003;
    c = 32'h0000_0010;
    wb(1'b1, IMU_OFF_FLAGS, 32'h0000_000F, 4'h1);
    for (int i = 0; i < 3; i++)
    begin
      e = (i == 0) ? a * b : (i == 1) ? a * b + c : c - a * b;
      run(ctl(3'(i), 1'b0, 1'b1, 1'b1, 4'h3, 4'h1, 4'h0), a, b, c, 32'h0, 32'h0);
      chk("low word", e, g_lo);
      chk("high word", 32'h0, g_hi);
      chk("strobes", {1'b1, 1'b0, 4'h3}, {g_lo_we, g_hi_we, g_lo_idx});
      chk("reg file", e, rf_u.regs_q[3]);
      chk("flags", 4'hF, g_flags);
    end
  endtask

  // flag form: low registers only, c and v preset and kept
  task automatic t_flags;
    wb(1'b1, IMU_OFF_FLAGS, 32'h0000_0003, 4'h1);
    run(ctl(3'h0, 1'b1, 1'b1, 1'b1, 4'h2, 4'h1, 4'h0), 32'h0, 32'h5, 32'h0, 32'h0, 32'h0);
    chk("zero flags", 4'h7, g_flags);
    run(ctl(3'h0, 1'b1, 1'b1, 1'b1, 4'h2, 4'h1, 4'h0), 32'hFFFF_FFFF, 32'h1, 32'h0, 32'h0, 32'h0);
    chk("negative flags", 4'hB, g_flags);
  endtask

  // destination left out goes to the first operand register
  task automatic t_dest;
    run(ctl(3'h0, 1'b0, 1'b1, 1'b0, 4'h2, 4'h6, 4'h0), 32'h0000_1234, 32'h10, 32'h0, 32'h0, 32'h0);
    chk("default index", 4'h6, g_lo_idx);
    chk("default reg", 32'h0001_2340, rf_u.regs_q[6]);
  endtask

  // wide family at the all-ones corner where any carry slip shows
  task automatic t_wide;
    logic [63:0] p, e;
    logic [31:0] m;
    m = 32'hFFFF_FFFF;
    p = {32'h0, m} * {32'h0, m};
    wb(1'b1, IMU_OFF_FLAGS, 32'h0000_0005, 4'h1);
    for (int i = 3; i < 6; i++)
    begin
      e = (i == 3) ? p : (i == 4) ? p + {32'h0, m} + {32'h0, m} : p + {m, m};
      run(ctl(3'(i), 1'b0, 1'b1, 1'b1, 4'h4, 4'h1, 4'h5), m, m, 32'h0, m, m);
      chk("wide result", e, {g_hi, g_lo});
      chk("wide strobes", {2'b11, 4'h5, 4'h4}, {g_lo_we, g_hi_we, g_hi_idx, g_lo_idx});
      chk("wide pair", e, {rf_u.regs_q[5], rf_u.regs_q[4]});
      chk("wide flags", 4'h5, g_flags);
    end
  endtask

  // failed condition: nothing written, flags kept, done still seen
  task automatic t_cond;
    int w;
    wb(1'b1, IMU_OFF_FLAGS, 32'h0000_0009, 4'h1);
    w = rf_u.n_wr;
    run(ctl(3'h0, 1'b1, 1'b0, 1'b1, 4'h2, 4'h1, 4'h0), 32'h0, 32'h0, 32'h0, 32'h0, 32'h0);
    chk("cond strobes", 2'b00, {g_lo_we, g_hi_we});
    chk("cond flags", 4'h9, g_flags);
    run(ctl(3'h5, 1'b0, 1'b0, 1'b1, 4'h2, 4'h1, 4'h3), 32'h7, 32'h7, 32'h0, 32'h1, 32'h1);
    chk("cond writes", w, rf_u.n_wr);
  endtask

  // undefined op, status sticky bit and an unmapped read
  task automatic t_bad;
    run(ctl(3'h6, 1'b0, 1'b1, 1'b1, 4'h2, 4'h1, 4'h3), 32'h7, 32'h7, 32'h0, 32'h0, 32'h0);
    chk("bad strobes", 2'b00, {g_lo_we, g_hi_we});
    wb(1'b0, IMU_OFF_STATUS, 32'h0, 4'hF);
    chk("bad status", 1'b1, rd_q[IMU_ST_BAD]);
    wb(1'b1, IMU_OFF_STATUS, 32'h0000_0006, 4'h1);
    wb(1'b0, IMU_OFF_STATUS, 32'h0, 4'hF);
    chk("status cleared", 32'h0, rd_q);
    wb(1'b0, 8'h40, 32'h0, 4'hF);
    chk("unmapped read", 32'h0, rd_q);
  endtask

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, IMU_OFF_FLAGS, 32'h0, 4'hF);
    chk("flags reset", 32'h0, rd_q);
    t_narrow();
    t_flags();
    t_dest();
    t_wide();
    t_cond();
    t_bad();
    give_verdict();
  end
endmodule
`default_nettype wire
